//--- inc/dpi_map.svh
/*
 Timing constants and field positions of the power-up sequencer of the memory device.
 Assumes inclusion by bare name from design files; it holds definitions only.
*/
`ifndef DPI_MAP_SVH
`define DPI_MAP_SVH
// ****************************************
// Clock and timing figures
// ****************************************
`define DPI_CLK_PERIOD_NS 40
`define DPI_AUTO_INIT_MAX_TIME_US 10
`define DPI_AUTO_INIT_MAX_CYC ((`DPI_AUTO_INIT_MAX_TIME_US * 1000) / `DPI_CLK_PERIOD_NS)
`define DPI_INIT_CAL_TIME_US 1
`define DPI_INIT_CAL_CYC (((`DPI_INIT_CAL_TIME_US * 1000) + `DPI_CLK_PERIOD_NS - 1) / `DPI_CLK_PERIOD_NS)
`define DPI_AUTO_INIT_WORK_CYC 100
// ****************************************
// Mode register addresses and fields
// ****************************************
`define DPI_MA_DEVICE_INFO 8'h00
`define DPI_MA_CAL_CMD 8'h0A
`define DPI_MA_TERM_CFG 8'h0B
`define DPI_MA_RESET 8'h3F
`define DPI_AUTO_INIT_FLAG_BIT 0
`define DPI_TERM_FIELD_LSB 0
`define DPI_TERM_FIELD_W 2
`endif

//--- inc/dpi_pkg.sv
/*
 Types shared by the power-up sequencer files.
 Assumes no other package; constants live in dpi_map.svh.
*/
package dpi_pkg;
   // ****************************************
   // Decoded command from the CA bus
   // ****************************************
   typedef enum logic [2:0] {
      DPI_CMD_NOP,
      DPI_CMD_MRW,
      DPI_CMD_MRR,
      DPI_CMD_PREA,
      DPI_CMD_TRAIN,
      DPI_CMD_OTHER
   } dpi_cmd_t;
   typedef struct packed {
      dpi_cmd_t kind;
      logic [7:0] addr;
      logic [7:0] data;
   } dpi_req_t;
   typedef enum logic [2:0] {
      DPI_ST_OFF,
      DPI_ST_NOP_WAIT,
      DPI_ST_AUTO_INIT,
      DPI_ST_IDLE,
      DPI_ST_CALIB,
      DPI_ST_READY
   } dpi_state_t;
endpackage : dpi_pkg

//--- verilog/dpi_timer.sv
/*
 Down-counting interval timer used for each timed phase of the sequencer.
 Assumes a single clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module dpi_timer #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   // Status
   output logic expired
);
   logic [WIDTH-1:0] remain;
   logic running;

   // ****************************************
   // Counter
   // ****************************************
   // A load restarts the interval even when one is already running.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         remain <= '0;
         running <= 1'b0;
      end else if (load) begin
         remain <= count;
         running <= 1'b1;
      end else if (running && remain != '0) begin
         remain <= remain - 1'b1;
      end else begin
         running <= 1'b0;
      end
   end

   // Expired is high for one cycle when the count reaches zero.
   assign expired = running && !load && remain == '0;
endmodule // dpi_timer

//--- verilog/dpi_seq.sv
/*
 Device-side power-up and initialization sequencer of a low-power DRAM.
 Assumes the CA bus is already decoded into one command per sys_clk cycle by the
 front end, and that CKE and ODT are sampled on the same clock.
*/
`timescale 1ns/1ns
`include "dpi_map.svh"
module dpi_seq #(
   parameter int AUTO_INIT_MAX_CYC = `DPI_AUTO_INIT_MAX_CYC,
   parameter int AUTO_INIT_WORK_CYC = `DPI_AUTO_INIT_WORK_CYC,
   parameter int INIT_CAL_CYC = `DPI_INIT_CAL_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Pins from the controller
   input wire logic cke,
   input wire logic caFloat,
   input wire dpi_pkg::dpi_req_t req,
   // Read data answer
   output logic [7:0] readData,
   output logic readValid,
   output logic readOe,
   // Status
   output logic autoInitFlag,
   output logic deviceIdle,
   output logic deviceReady,
   output logic termEnable,
   output logic [`DPI_TERM_FIELD_W-1:0] termSetting,
   output logic illegalCmd,
   output dpi_pkg::dpi_state_t seqState
);
   dpi_pkg::dpi_state_t state;
   dpi_pkg::dpi_state_t next_state;
   dpi_pkg::dpi_cmd_t cmd;
   logic isReset;
   logic isCal;
   logic isTermWrite;
   logic [15:0] workCnt;
   logic maxLoad;
   logic maxExpired;
   logic calLoad;
   logic calExpired;
   logic cmdAllowed;
   logic [15:0] calAge;

   // ****************************************
   // Command classification
   // ****************************************
   // A floating bus is forced to NOP so stray levels never decode as commands.
   assign cmd = caFloat ? dpi_pkg::DPI_CMD_NOP : req.kind;
   assign isReset = cke && cmd == dpi_pkg::DPI_CMD_MRW && req.addr == `DPI_MA_RESET;
   assign isCal = cke && cmd == dpi_pkg::DPI_CMD_MRW && req.addr == `DPI_MA_CAL_CMD;
   assign isTermWrite = cke && cmd == dpi_pkg::DPI_CMD_MRW && req.addr == `DPI_MA_TERM_CFG;

   // ****************************************
   // Timers
   // ****************************************
   assign maxLoad = isReset;
   assign calLoad = isCal && (state == dpi_pkg::DPI_ST_IDLE);

   dpi_timer #(.WIDTH(16)) i_dpi_timer_max (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(maxLoad),
      .count(16'(AUTO_INIT_MAX_CYC - 1)),
      .expired(maxExpired)
   );

   dpi_timer #(.WIDTH(16)) i_dpi_timer_cal (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(calLoad),
      .count(16'(INIT_CAL_CYC - 1)),
      .expired(calExpired)
   );

   // Internal auto-init work takes fewer cycles than the guaranteed maximum.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         workCnt <= '0;
      end else if (isReset) begin
         workCnt <= 16'(AUTO_INIT_WORK_CYC);
      end else if (state == dpi_pkg::DPI_ST_AUTO_INIT && workCnt != '0) begin
         workCnt <= workCnt - 16'h0001;
      end
   end

   // Cycles since the calibration command; it saturates so a long ready phase cannot wrap it.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         calAge <= '0;
      end else if (isReset) begin
         calAge <= '0;
      end else if (calLoad) begin
         calAge <= 16'h0001;
      end else if (calAge != '0 && calAge != 16'hFFFF) begin
         calAge <= calAge + 16'h0001;
      end
   end

   // ****************************************
   // Sequence state
   // ****************************************
   always_comb begin
      next_state = state;
      case (state)
         dpi_pkg::DPI_ST_OFF: begin
            if (cke) begin
               next_state = dpi_pkg::DPI_ST_NOP_WAIT;
            end
         end
         dpi_pkg::DPI_ST_AUTO_INIT: begin
            // Either the internal work or the maximum time ends auto-init.
            if (workCnt == '0 || maxExpired) begin
               next_state = dpi_pkg::DPI_ST_IDLE;
            end
         end
         dpi_pkg::DPI_ST_IDLE: begin
            if (isCal) begin
               next_state = dpi_pkg::DPI_ST_CALIB;
            end
         end
         dpi_pkg::DPI_ST_CALIB: begin
            if (calExpired) begin
               next_state = dpi_pkg::DPI_ST_READY;
            end
         end
         default: begin
            next_state = state;
         end
      endcase
      // A reset command restarts at the same step from any phase.
      if (isReset) begin
         next_state = dpi_pkg::DPI_ST_AUTO_INIT;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= dpi_pkg::DPI_ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // Flag, termination and status
   // ****************************************
   // The flag is set by reset and cleared when auto-init completes.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         autoInitFlag <= 1'b1;
      end else if (isReset) begin
         autoInitFlag <= 1'b1;
      end else if (state == dpi_pkg::DPI_ST_AUTO_INIT && next_state == dpi_pkg::DPI_ST_IDLE) begin
         autoInitFlag <= 1'b0;
      end
   end

   // Termination only enables after ready; writes earlier are ignored.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         termEnable <= 1'b0;
         termSetting <= '0;
      end else if (isReset) begin
         termEnable <= 1'b0;
         termSetting <= '0;
      end else if (isTermWrite && state == dpi_pkg::DPI_ST_READY) begin
         termSetting <= req.data[`DPI_TERM_FIELD_LSB +: `DPI_TERM_FIELD_W];
         termEnable <= req.data[`DPI_TERM_FIELD_LSB +: `DPI_TERM_FIELD_W] != '0;
      end
   end

   // In NOP-wait and auto-init only reads, NOPs, precharge-all and reset are accepted; others are flagged.
   always_comb begin
      cmdAllowed = 1'b1;
      if (state == dpi_pkg::DPI_ST_AUTO_INIT || state == dpi_pkg::DPI_ST_NOP_WAIT) begin
         cmdAllowed = cmd == dpi_pkg::DPI_CMD_NOP || cmd == dpi_pkg::DPI_CMD_MRR
            || cmd == dpi_pkg::DPI_CMD_PREA || isReset;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         illegalCmd <= 1'b0;
      end else begin
         illegalCmd <= cke && !cmdAllowed;
      end
   end

   // ****************************************
   // Mode register read answer
   // ****************************************
   // The device info register reports the flag; other reads return zero here.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         readData <= 8'h00;
         readValid <= 1'b0;
      end else begin
         readValid <= cke && cmd == dpi_pkg::DPI_CMD_MRR;
         readData <= 8'h00;
         if (req.addr == `DPI_MA_DEVICE_INFO) begin
            readData[`DPI_AUTO_INIT_FLAG_BIT] <= autoInitFlag;
         end
      end
   end

   // Outputs float whenever CKE is low.
   assign readOe = readValid && cke;
   assign deviceIdle = state == dpi_pkg::DPI_ST_IDLE || state == dpi_pkg::DPI_ST_CALIB
      || state == dpi_pkg::DPI_ST_READY;
   assign deviceReady = state == dpi_pkg::DPI_ST_READY;
   assign seqState = state;

   // ****************************************
   // Checks
   // ****************************************
   AST_OE_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n) !cke |-> !readOe)
      else $error("Output enabled while CKE low.");
   AST_FLOAT_NOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      caFloat |=> !illegalCmd)
      else $error("Floating bus decoded as a command.");
   AST_FLAG_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cke && cmd == dpi_pkg::DPI_CMD_MRR && req.addr == `DPI_MA_DEVICE_INFO)
      |=> readValid && readData[0] == $past(autoInitFlag))
      else $error("Flag read returned wrong value.");
   AST_IDLE_BOUND: assert property (@(posedge sys_clk) disable iff (!rst_n)
      isReset |=> autoInitFlag ##[1:AUTO_INIT_MAX_CYC] !autoInitFlag)
      else $error("Auto-init exceeded the maximum time.");
   AST_READY_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      calLoad && !isReset |=> !deviceReady [*8])
      else $error("Ready too soon after calibration.");
   // The short window above cannot cover the whole calibration time, so the age counter does.
   AST_READY_TIME: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(deviceReady) |-> calAge > 16'(INIT_CAL_CYC))
      else $error("Ready sooner than the calibration time.");
   AST_TERM_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
      isReset |=> !termEnable)
      else $error("Termination on after reset.");
   AST_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_n)
      isReset |=> state == dpi_pkg::DPI_ST_AUTO_INIT)
      else $error("Reset did not restart auto-init.");
   AST_BEFORE_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == dpi_pkg::DPI_ST_AUTO_INIT && cke && cmd == dpi_pkg::DPI_CMD_MRW && !isReset)
      |=> illegalCmd)
      else $error("Write before idle not flagged.");
endmodule // dpi_seq

//--- bench/dpi_host_model.sv
/*
 Behavioural model of the host controller that drives CKE and the CA bus.
 Assumes a testbench calls its tasks in sequence order and wires its ports.
*/
`timescale 1ns/1ns
module dpi_host_model #(
   parameter int CKE_LOW_CYC = 5,
   parameter int POST_CKE_NOP_CYC = 5000,
   parameter int POST_RESET_NOP_CYC = 25
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Command side
   output logic cke,
   output logic caFloat,
   output dpi_pkg::dpi_req_t req,
   output logic odt,
   // Read answer
   input wire logic [7:0] readData,
   input wire logic readValid
);
   // ****************************************
   // Command drivers
   // ****************************************
   // The bus idles on NOP so nothing stray is ever taken.
   initial begin
      cke = 1'b0;
      caFloat = 1'b0;
      odt = 1'b0;
      req = '{dpi_pkg::DPI_CMD_NOP, 8'h00, 8'h00};
   end
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // One command for one cycle, then NOP; settled values are visible on return.
   task automatic send(input dpi_pkg::dpi_cmd_t k, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{k, a, d};
      @(posedge sys_clk);
      req <= '{dpi_pkg::DPI_CMD_NOP, 8'h00, 8'h00};
      #1;
   endtask
   // Low time covers both 100 ns (3 cycles) and 5 stable clocks, rounded up.
   task automatic powerUp();
      idle(CKE_LOW_CYC);
      @(posedge sys_clk);
      cke <= 1'b1;
      idle(POST_CKE_NOP_CYC);
   endtask
   task automatic waitReset();
      idle(POST_RESET_NOP_CYC);
   endtask
   // Poll the flag until clear; a bound keeps a stuck device from hanging us.
   task automatic pollFlag(input int maxPolls, output bit done);
      done = 1'b0;
      for (int i = 0; i < maxPolls && !done; i++) begin
         send(dpi_pkg::DPI_CMD_MRR, 8'h00, 8'h00);
         done = readValid && (readData[0] === 1'b0);
      end
   endtask
   // A released bus carries a dangerous write pattern, not a tidy NOP.
   task automatic floatCycle(input logic [7:0] a);
      @(posedge sys_clk);
      caFloat <= 1'b1;
      req <= '{dpi_pkg::DPI_CMD_MRW, a, 8'hA5};
      @(posedge sys_clk);
      caFloat <= 1'b0;
      req <= '{dpi_pkg::DPI_CMD_NOP, 8'h00, 8'h00};
      #1;
   endtask
endmodule // dpi_host_model

//--- bench/dpi_seq_tb.sv
/*
 Self-checking testbench of the power-up sequencer.
 Assumes dpi_pkg, dpi_map.svh and the host model are compiled first.
*/
`timescale 1ns/1ns
`include "dpi_map.svh"
`define DPI_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module dpi_seq_tb;
   localparam int MAX_CYC = 60;
   localparam int WORK_CYC = 40;
   localparam int CAL_CYC = 8;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cke;
   logic caFloat;
   dpi_pkg::dpi_req_t req;
   logic [7:0] readData;
   logic readValid, readOe, autoInitFlag, deviceIdle, deviceReady, termEnable, illegalCmd;
   logic [`DPI_TERM_FIELD_W-1:0] termSetting;
   dpi_pkg::dpi_state_t seqState;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   bit done;
   int cnt;
   // ****************************************
   // Clock, instances, watchdog
   // ****************************************
   always #20 sys_clk = ~sys_clk;
   dpi_seq #(.AUTO_INIT_MAX_CYC(MAX_CYC), .AUTO_INIT_WORK_CYC(WORK_CYC), .INIT_CAL_CYC(CAL_CYC)) i_dpi_seq (
      .sys_clk(sys_clk), .rst_n(rst_n), .cke(cke), .caFloat(caFloat), .req(req),
      .readData(readData), .readValid(readValid), .readOe(readOe), .autoInitFlag(autoInitFlag),
      .deviceIdle(deviceIdle), .deviceReady(deviceReady), .termEnable(termEnable),
      .termSetting(termSetting), .illegalCmd(illegalCmd), .seqState(seqState));
   dpi_host_model i_host (.sys_clk(sys_clk), .rst_n(rst_n), .cke(cke), .caFloat(caFloat), .req(req),
      .odt(), .readData(readData), .readValid(readValid));
   // The post-CKE NOP wait dominates at about 5200 cycles; 8000 means a hang.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 8000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   // A read while CKE is low must never turn the outputs on.
   task automatic t_power();
      `DPI_CHK(autoInitFlag, 1'b1)
      i_host.send(dpi_pkg::DPI_CMD_MRR, `DPI_MA_DEVICE_INFO, 8'h00);
      `DPI_CHK(readOe, 1'b0)
      `DPI_CHK(seqState, dpi_pkg::DPI_ST_OFF)
      i_host.powerUp();
      `DPI_CHK(seqState, dpi_pkg::DPI_ST_NOP_WAIT)
      // The optional precharge before reset is accepted and changes no step.
      i_host.send(dpi_pkg::DPI_CMD_PREA, 8'h00, 8'h00);
      `DPI_CHK({illegalCmd, seqState == dpi_pkg::DPI_ST_NOP_WAIT}, 2'h1)
   endtask
   // Reset, floating bus, refused write, busy flag read, then polling to idle.
   task automatic t_reset();
      i_host.send(dpi_pkg::DPI_CMD_MRW, `DPI_MA_RESET, 8'h00);
      `DPI_CHK(seqState, dpi_pkg::DPI_ST_AUTO_INIT)
      i_host.waitReset();
      i_host.floatCycle(8'h01);
      `DPI_CHK(illegalCmd, 1'b0)
      i_host.send(dpi_pkg::DPI_CMD_MRW, 8'h01, 8'h00);
      `DPI_CHK(illegalCmd, 1'b1)
      i_host.send(dpi_pkg::DPI_CMD_MRR, `DPI_MA_DEVICE_INFO, 8'h00);
      `DPI_CHK({readValid, readOe, readData[0]}, 3'h7)
      i_host.pollFlag(MAX_CYC / 2, done);
      `DPI_CHK({done, deviceIdle, autoInitFlag}, 3'h6)
      i_host.floatCycle(`DPI_MA_RESET);
      `DPI_CHK(seqState, dpi_pkg::DPI_ST_IDLE)
   endtask
   // Early termination write is dropped; ready waits the full calibration time.
   task automatic t_cal();
      i_host.send(dpi_pkg::DPI_CMD_MRW, `DPI_MA_TERM_CFG, 8'h01);
      `DPI_CHK(termEnable, 1'b0)
      // No training and a single device, so calibration follows idle directly.
      i_host.send(dpi_pkg::DPI_CMD_MRW, `DPI_MA_CAL_CMD, 8'hFF);
      cnt = 0;
      while (!deviceReady && cnt < CAL_CYC + 3) begin
         i_host.idle(1);
         cnt++;
      end
      `DPI_CHK(cnt >= CAL_CYC, 1'b1)
      `DPI_CHK(deviceReady, 1'b1)
      for (int r = 1; r <= 3; r++) begin
         i_host.send(dpi_pkg::DPI_CMD_MRW, 8'(r), 8'h00);
         `DPI_CHK(illegalCmd, 1'b0)
      end
      i_host.send(dpi_pkg::DPI_CMD_MRW, `DPI_MA_TERM_CFG, 8'h02);
      `DPI_CHK({termEnable, termSetting}, 3'h6)
   endtask
   // Reset without a ramp restarts; idle comes without any flag read.
   task automatic t_rerun();
      i_host.send(dpi_pkg::DPI_CMD_MRW, `DPI_MA_RESET, 8'h00);
      `DPI_CHK(seqState, dpi_pkg::DPI_ST_AUTO_INIT)
      `DPI_CHK({deviceReady, termEnable, autoInitFlag}, 3'h1)
      i_host.idle(MAX_CYC);
      `DPI_CHK({deviceIdle, autoInitFlag}, 2'h2)
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      t_power();
      t_reset();
      t_cal();
      t_rerun();
      finish_test();
   end
endmodule // dpi_seq_tb
